// >>> pkg/loop_ctrl_pkg.sv
// Constants for the digital loop mode control block.
// Assumes an 8-bit register port with indexed register selection.
package loop_ctrl_pkg;
   // ******************************
   // Register indices
   // ******************************
   localparam logic [1:0] IDX_REF_FB = 2'h0;
   localparam logic [1:0] IDX_MODE = 2'h1;
   localparam logic [1:0] IDX_DECIM = 2'h2;
   // ******************************
   // Reset values
   // ******************************
   localparam logic [7:0] RST_REF_FB = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h81;
   localparam logic [7:0] RST_DECIM = 8'h36;
   // ******************************
   // Writable bit masks, reserved read-only bits read zero
   // ******************************
   localparam logic [7:0] MASK_REF_FB = 8'hD3;
   localparam logic [7:0] MASK_MODE = 8'hFF;
   localparam logic [7:0] MASK_DECIM = 8'h7F;
   // ******************************
   // Field positions
   // ******************************
   localparam int POS_POLICY = 6;
   localparam int POS_MANSEL = 4;
   localparam int POS_REVERT = 1;
   localparam int POS_HITLESS = 0;
   localparam int POS_AUTOBW = 7;
   localparam int POS_LOSSPOL = 6;
   localparam int POS_INHIBIT = 3;
   localparam int POS_ENABLE = 2;
   localparam int POS_STATESEL = 0;
   localparam int POS_HDEC = 4;
   localparam int POS_MDEC = 0;
   localparam logic [1:0] POLICY_AUTO = 2'h2;
   localparam logic [1:0] SEL_FREERUN = 2'h0;
   localparam logic [1:0] SEL_NORMAL = 2'h1;
   localparam logic [1:0] SEL_HOLDOVER = 2'h2;
   localparam logic [1:0] SEL_WRFREQ = 2'h3;
   localparam logic [2:0] HDEC_OFF = 3'h0;
   typedef enum logic [2:0] {ST_FREERUN, ST_ACQUIRE, ST_LOCKED, ST_HOLDOVER, ST_WRFREQ}
      loop_state_t;
endpackage : loop_ctrl_pkg

// >>> rtl/loop_reg8.sv
// One 8-bit software register with a writable-bit mask.
// Assumes a single-cycle write strobe synchronous to CLOCK.
`timescale 1ns/1ps
module loop_reg8
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hFF
)
(
   input wire logic clk, // System clock
   input wire logic rst, // Async reset
   input wire logic we, // Write strobe
   input wire logic [7:0] wdata, // Write data
   output logic [7:0] q // Register value
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      if (we)
      begin
         q_nxt = wdata & WMASK;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q_r <= RESET_VAL & WMASK;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : loop_reg8

// >>> rtl/loop_mode_ctrl.sv
// Mode control of the digital phase-locked loop: reference choice, state, bandwidth.
// Assumes register access by index over an 8-bit port, and reference valid
// and lock indications from the monitor and loop logic, all on CLOCK.
// What this block does
// - Two-bit policy field: 0 manual choice bit, 2 automatic reference selection.
// - Manual choice bit: 0 first clock input, 1 second clock input.
// - Revertive bit: 1 returns to preferred reference once it is valid.
// - Hitless bit enables phase-hitless reference switching.
// - Auto bandwidth bit set: locking settings in Acquire; clear: normal always.
// - Reference loss goes to Holdover if policy bit 0, Freerun if 1.
// - Frequency-word writes allowed anytime; device suppresses filter update itself.
// - Enable 0: synthesizer mode, gate loop except filter and scaler.
// - State field: 0 Freerun, 1 Normal, 2 Holdover, 3 Write Frequency.
// - Hitless decimator shift sets bandwidth during hitless or holdover exit.
// - Hitless decimator shift ignored when hitless switching is off.
// - Main decimator shift sets bandwidth; zero means feed-through.
`timescale 1ns/1ps
module loop_mode_ctrl
   import loop_ctrl_pkg::*;
(
   input wire logic CLOCK, // 200 MHz system clock
   input wire logic RST, // Async reset, active high
   input wire logic [1:0] REG_IDX, // Register index
   input wire logic REG_WE, // Register write strobe
   input wire logic [7:0] REG_WDATA, // Register write data
   output logic [7:0] REG_RDATA, // Register read data
   input wire logic FREQ_WORD_WE, // Frequency-word register write strobe
   input wire logic FIRST_CLOCK_INPUT_VALID, // First reference qualified
   input wire logic SECOND_CLOCK_INPUT_VALID, // Second reference qualified
   input wire logic LOOP_LOCKED, // Loop lock indication
   output logic REF_SELECT, // 0 first, 1 second clock input
   output logic [2:0] LOOP_STATE, // Current loop state
   output logic USE_ACQUIRE_BW, // Use locking bandwidth and damping
   output logic FILTER_UPDATE_EN, // Loop filter may update
   output logic LOOP_CLK_EN, // Gate enable for loop logic
   output logic HITLESS_EN, // Hitless switching active
   output logic [2:0] HITLESS_DEC_SHIFT, // Effective hitless decimator shift
   output logic [3:0] MAIN_DEC_SHIFT, // Main decimator shift
   output logic DEC_FEEDTHROUGH, // Main decimator bypassed
   output logic PHASE_MEASURE // Hitless phase measurement window
);
   // ******************************
   // Registers
   // ******************************
   logic [7:0] ref_fb_q;
   logic [7:0] mode_q;
   logic [7:0] decim_q;

   loop_reg8 #(.RESET_VAL(RST_REF_FB), .WMASK(MASK_REF_FB)) u_ref_fb
   (
      .clk(CLOCK),
      .rst(RST),
      .we(REG_WE && REG_IDX == IDX_REF_FB),
      .wdata(REG_WDATA),
      .q(ref_fb_q)
   );
   loop_reg8 #(.RESET_VAL(RST_MODE), .WMASK(MASK_MODE)) u_mode
   (
      .clk(CLOCK),
      .rst(RST),
      .we(REG_WE && REG_IDX == IDX_MODE),
      .wdata(REG_WDATA),
      .q(mode_q)
   );
   loop_reg8 #(.RESET_VAL(RST_DECIM), .WMASK(MASK_DECIM)) u_decim
   (
      .clk(CLOCK),
      .rst(RST),
      .we(REG_WE && REG_IDX == IDX_DECIM),
      .wdata(REG_WDATA),
      .q(decim_q)
   );

   always_comb
   begin
      unique case (REG_IDX)
         IDX_REF_FB: REG_RDATA = ref_fb_q;
         IDX_MODE: REG_RDATA = mode_q;
         IDX_DECIM: REG_RDATA = decim_q;
         default: REG_RDATA = 8'h00;
      endcase
   end

   // ******************************
   // Field decode
   // ******************************
   logic [1:0] policy;
   logic auto_sel;
   logic manual_sel;
   logic revertive;
   logic hitless;
   logic auto_bandwidth_switch;
   logic ref_loss_policy;
   logic inhibit;
   logic loop_en;
   logic [1:0] state_sel;
   logic [2:0] hitless_decimator_shift;
   logic [3:0] main_decimator_shift;

   assign policy = ref_fb_q[POS_POLICY +: 2];
   assign auto_sel = (policy == POLICY_AUTO);
   assign manual_sel = ref_fb_q[POS_MANSEL];
   assign revertive = ref_fb_q[POS_REVERT];
   assign hitless = ref_fb_q[POS_HITLESS];
   assign auto_bandwidth_switch = mode_q[POS_AUTOBW];
   assign ref_loss_policy = mode_q[POS_LOSSPOL];
   assign inhibit = mode_q[POS_INHIBIT];
   assign loop_en = mode_q[POS_ENABLE];
   assign state_sel = mode_q[POS_STATESEL +: 2];
   assign hitless_decimator_shift = decim_q[POS_HDEC +: 3];
   assign main_decimator_shift = decim_q[POS_MDEC +: 4];

   // ******************************
   // Reference selection
   // ******************************
   logic ref_r;
   logic ref_nxt;
   logic cur_valid;
   logic other_valid;
   logic pref_valid;

   assign cur_valid = ref_r ? SECOND_CLOCK_INPUT_VALID : FIRST_CLOCK_INPUT_VALID;
   assign other_valid = ref_r ? FIRST_CLOCK_INPUT_VALID : SECOND_CLOCK_INPUT_VALID;
   assign pref_valid = FIRST_CLOCK_INPUT_VALID;

   // Automatic mode prefers the first input; switches only on loss unless revertive
   always_comb
   begin
      ref_nxt = ref_r;
      if (!auto_sel)
      begin
         ref_nxt = manual_sel;
      end
      else if (revertive && ref_r && pref_valid)
      begin
         ref_nxt = 1'b0;
      end
      else if (!cur_valid && other_valid)
      begin
         ref_nxt = !ref_r;
      end
   end

   // ******************************
   // Loop state machine
   // ******************************
   loop_state_t state_r;
   loop_state_t state_nxt;
   logic switched;
   logic meas_r;
   logic meas_nxt;

   assign switched = (ref_nxt != ref_r);

   always_comb
   begin
      state_nxt = state_r;
      if (!loop_en)
      begin
         // Synthesizer mode runs open loop
         state_nxt = (state_sel == SEL_WRFREQ) ? ST_WRFREQ : ST_FREERUN;
      end
      else
      begin
         unique case (state_sel)
            SEL_FREERUN: state_nxt = ST_FREERUN;
            SEL_HOLDOVER: state_nxt = ST_HOLDOVER;
            SEL_WRFREQ: state_nxt = ST_WRFREQ;
            SEL_NORMAL:
            begin
               unique case (state_r)
                  ST_FREERUN, ST_HOLDOVER, ST_WRFREQ:
                     if (cur_valid && !switched)
                     begin
                        state_nxt = ST_ACQUIRE;
                     end
                  ST_ACQUIRE, ST_LOCKED:
                     if (!cur_valid && !(auto_sel && other_valid))
                     begin
                        state_nxt = ref_loss_policy ? ST_FREERUN : ST_HOLDOVER;
                     end
                     else if (state_r == ST_ACQUIRE && LOOP_LOCKED)
                     begin
                        state_nxt = ST_LOCKED;
                     end
                     else if (state_r == ST_LOCKED && !LOOP_LOCKED)
                     begin
                        state_nxt = ST_ACQUIRE;
                     end
               endcase
            end
         endcase
      end
   end

   // Phase measurement window on hitless switch or holdover exit
   always_comb
   begin
      meas_nxt = 1'b0;
      if (hitless && loop_en)
      begin
         meas_nxt = (switched && state_r == ST_LOCKED)
            || (state_r == ST_HOLDOVER && state_nxt == ST_ACQUIRE);
      end
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         ref_r <= 1'b0;
         state_r <= ST_FREERUN;
         meas_r <= 1'b0;
      end
      else
      begin
         ref_r <= ref_nxt;
         state_r <= state_nxt;
         meas_r <= meas_nxt;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign REF_SELECT = ref_r;
   assign LOOP_STATE = state_r;
   assign USE_ACQUIRE_BW = auto_bandwidth_switch && state_r == ST_ACQUIRE;
   // Frequency-word write suppresses the update in that cycle only
   assign FILTER_UPDATE_EN = !inhibit && !FREQ_WORD_WE;
   assign LOOP_CLK_EN = loop_en;
   assign HITLESS_EN = hitless;
   assign HITLESS_DEC_SHIFT = hitless ? hitless_decimator_shift : HDEC_OFF;
   assign MAIN_DEC_SHIFT = main_decimator_shift;
   assign DEC_FEEDTHROUGH = (main_decimator_shift == 4'h0);
   assign PHASE_MEASURE = meas_r;

   // ******************************
   // Checks
   // ******************************
   a_loss_policy: assert property (@(posedge CLOCK) disable iff (RST)
      (loop_en && state_sel == SEL_NORMAL && state_r == ST_LOCKED && !cur_valid
       && !(auto_sel && other_valid)) |=> (state_r == (ref_loss_policy ? ST_FREERUN : ST_HOLDOVER)))
      else $error("reference loss state wrong");
   a_manual_ref: assert property (@(posedge CLOCK) disable iff (RST)
      !auto_sel |=> (ref_r == $past(manual_sel)))
      else $error("manual reference not followed");
   a_forced_state: assert property (@(posedge CLOCK) disable iff (RST)
      (loop_en && state_sel == SEL_HOLDOVER) |=> state_r == ST_HOLDOVER)
      else $error("forced holdover not taken");
   a_acq_bw: assert property (@(posedge CLOCK) disable iff (RST)
      (!REG_WE && auto_bandwidth_switch && loop_en && state_sel == SEL_NORMAL
       && state_r == ST_FREERUN && cur_valid && !switched) |=> USE_ACQUIRE_BW)
      else $error("acquire bandwidth not used");
   a_freq_suppress: assert property (@(posedge CLOCK) disable iff (RST)
      FREQ_WORD_WE |-> !FILTER_UPDATE_EN)
      else $error("filter updated on frequency write");
   a_synth_mode: assert property (@(posedge CLOCK) disable iff (RST)
      !loop_en ##1 !loop_en |-> (state_r == ST_FREERUN || state_r == ST_WRFREQ))
      else $error("synthesizer mode in closed loop");
   a_hitless_ignore: assert property (@(posedge CLOCK) disable iff (RST)
      !hitless |-> (HITLESS_DEC_SHIFT == HDEC_OFF && !PHASE_MEASURE))
      else $error("hitless field not ignored");
   a_revert_back: assert property (@(posedge CLOCK) disable iff (RST)
      (auto_sel && revertive && ref_r && pref_valid) |=> !ref_r)
      else $error("revertive switch missed");
   a_reserved_zero: assert property (@(posedge CLOCK) disable iff (RST)
      (REG_IDX == IDX_REF_FB) |-> (REG_RDATA[5] == 1'b0 && REG_RDATA[3:2] == 2'h0))
      else $error("reserved bits not zero");
endmodule : loop_mode_ctrl

// >>> sim/testbench.sv
// Self-checking bench for the loop mode control block.
// Assumes loop_ctrl_pkg and loop_mode_ctrl are compiled first.
`timescale 1ns/1ps
module testbench;
   import loop_ctrl_pkg::*;
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
   typedef struct {int sel; logic [7:0] exp;} note_t;
   logic clk = 1'b0, rst = 1'b1, we = 1'b0, fw = 1'b0, v1 = 1'b1, v2 = 1'b1, lk = 1'b0;
   logic [1:0] idx = 2'h0;
   logic [7:0] wd = 8'h00, rd, mode_sh = RST_MODE;
   logic rsel, acq, fen, cen, hen, feed, pm;
   logic [2:0] st, hsh;
   logic [3:0] msh;
   int error_cnt = 0, checks = 0;
   note_t q[$];
   event ev;
   loop_mode_ctrl i_loop_mode_ctrl (.CLOCK(clk), .RST(rst), .REG_IDX(idx), .REG_WE(we),
      .REG_WDATA(wd), .REG_RDATA(rd), .FREQ_WORD_WE(fw), .FIRST_CLOCK_INPUT_VALID(v1),
      .SECOND_CLOCK_INPUT_VALID(v2), .LOOP_LOCKED(lk), .REF_SELECT(rsel), .LOOP_STATE(st),
      .USE_ACQUIRE_BW(acq), .FILTER_UPDATE_EN(fen), .LOOP_CLK_EN(cen), .HITLESS_EN(hen),
      .HITLESS_DEC_SHIFT(hsh), .MAIN_DEC_SHIFT(msh), .DEC_FEEDTHROUGH(feed), .PHASE_MEASURE(pm));
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   function automatic logic [7:0] pick(input int s);
      case (s)
         0: return rd;
         1: return {7'h00, rsel};
         2: return {5'h00, st};
         3: return {7'h00, acq};
         4: return {7'h00, fen};
         5: return {7'h00, cen};
         6: return {7'h00, hen};
         7: return {5'h00, hsh};
         8: return {4'h0, msh};
         9: return {7'h00, feed};
         default: return {7'h00, pm};
      endcase
   endfunction : pick
   // ******************************
   // Result watcher
   // ******************************
   initial
   begin
      note_t n;
      forever
      begin
         @(ev);
         while (q.size() > 0)
         begin
            n = q.pop_front();
            `CMP(pick(n.sel), n.exp)
         end
      end
   end
   // Sample 1 ns after the falling edge; inputs move again only at the next one
   task automatic chk(input int s, input logic [7:0] e);
      q.push_back('{s, e});
      #1;
      ->ev;
      @(negedge clk);
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic wr(input logic [1:0] i, input logic [7:0] d);
      @(negedge clk);
      idx = i;
      wd = d;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
   endtask : wr
   task automatic rdc(input logic [1:0] i, input logic [7:0] e);
      idx = i;
      chk(0, e);
   endtask : rdc
   // Reconfiguring an enabled loop is bracketed by the inhibit bit
   task automatic cfg(input logic [1:0] i, input logic [7:0] d);
      logic en;
      en = mode_sh[POS_ENABLE];
      if (en) wr(IDX_MODE, mode_sh | 8'h08);
      if (en) chk(4, 8'h00);
      wr(i, (en && i == IDX_MODE) ? (d | 8'h08) : d);
      if (i == IDX_MODE) mode_sh = d;
      if (en) wr(IDX_MODE, mode_sh);
      step(3);
   endtask : cfg
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   initial
   begin
      #20000;
      error_cnt++;
      report_and_stop();
   end
   // ******************************
   // Main sequence
   // ******************************
   initial
   begin
      logic [7:0] d;
      logic [7:0] pol[3];
      logic [2:0] se[4];
      pol = '{8'h00, 8'h40, 8'hC0};
      se = '{ST_FREERUN, ST_LOCKED, ST_HOLDOVER, ST_WRFREQ};
      void'($urandom(32'h4726));
      step(16);
      rst = 1'b0;
      step(1);
      rdc(IDX_REF_FB, RST_REF_FB);
      rdc(IDX_MODE, RST_MODE);
      rdc(IDX_DECIM, RST_DECIM);
      rdc(2'h3, 8'h00);
      chk(8, 8'h06);
      chk(7, 8'h00);
      chk(5, 8'h00);
      for (int i = 0; i < 4; i++) wr(i[1:0], 8'hFF);
      rdc(IDX_REF_FB, 8'hD3);
      rdc(IDX_MODE, 8'hFF);
      rdc(IDX_DECIM, 8'h7F);
      rdc(2'h3, 8'h00);
      wr(IDX_MODE, RST_MODE);
      $display("test registers done");
      for (int i = 0; i < 10; i++)
      begin
         d = 8'($urandom());
         wr(IDX_REF_FB, {7'h00, d[7]});
         wr(IDX_DECIM, d);
         step(1);
         chk(6, {7'h00, d[7]});
         chk(7, d[7] ? {5'h00, d[6:4]} : 8'h00);
         chk(8, {4'h0, d[3:0]});
         chk(9, {7'h00, d[3:0] == 4'h0});
      end
      wr(IDX_DECIM, 8'h00);
      step(1);
      chk(9, 8'h01);
      $display("test decimator done");
      for (int p = 0; p < 3; p++)
         for (int s = 0; s < 2; s++)
         begin
            cfg(IDX_REF_FB, pol[p] | (s[0] ? 8'h10 : 8'h00));
            chk(1, {7'h00, s[0]});
         end
      cfg(IDX_REF_FB, 8'h80);
      chk(1, 8'h01);
      v2 = 1'b0;
      step(3);
      chk(1, 8'h00);
      v2 = 1'b1;
      v1 = 1'b0;
      step(3);
      chk(1, 8'h01);
      v1 = 1'b1;
      step(3);
      chk(1, 8'h01);
      cfg(IDX_REF_FB, 8'h82);
      chk(1, 8'h00);
      $display("test reference choice done");
      cfg(IDX_REF_FB, 8'h01);
      cfg(IDX_MODE, 8'h85);
      chk(2, {5'h00, ST_ACQUIRE});
      chk(3, 8'h01);
      chk(5, 8'h01);
      cfg(IDX_MODE, 8'h05);
      chk(3, 8'h00);
      lk = 1'b1;
      step(3);
      chk(2, {5'h00, ST_LOCKED});
      v1 = 1'b0;
      v2 = 1'b0;
      step(3);
      chk(2, {5'h00, ST_HOLDOVER});
      lk = 1'b0;
      v1 = 1'b1;
      step(1);
      chk(10, 8'h01);
      chk(2, {5'h00, ST_ACQUIRE});
      chk(10, 8'h00);
      lk = 1'b1;
      cfg(IDX_MODE, 8'hC5);
      chk(2, {5'h00, ST_LOCKED});
      v1 = 1'b0;
      step(3);
      chk(2, {5'h00, ST_FREERUN});
      v1 = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         cfg(IDX_MODE, 8'h84 | 8'(m));
         chk(2, {5'h00, se[m]});
      end
      fw = 1'b1;
      chk(4, 8'h00);
      fw = 1'b0;
      chk(4, 8'h01);
      cfg(IDX_MODE, 8'h81);
      chk(5, 8'h00);
      chk(2, {5'h00, ST_FREERUN});
      cfg(IDX_MODE, 8'h83);
      chk(2, {5'h00, ST_WRFREQ});
      $display("test loop state done");
      step(2);
      report_and_stop();
   end
endmodule : testbench
